// ===== test/dual_timer_checker.sv
/* Checker on the timer block's top ports.
   Assumes bind from the bench; mode and run bits are shadowed from writes. */
`timescale 1ns/1ps
module dual_timer_checker
    import timer_mode_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst,
    input wire reg_write_s regWr,
    input wire logic [7:0] rdAddr,
    input wire logic       ext_irq0_pin,
    input wire logic       t0_isr_enter,
    input wire logic       t1_isr_enter,
    input wire logic [7:0] rdData,
    input wire logic       t0_overflow_flag,
    input wire logic       t1_overflow_flag
);
    logic [7:0] modeSh_ff, nxt_modeSh;
    logic [1:0] run_ff, nxt_run;
    logic       ctrlWr, wrL0;
    assign ctrlWr = regWr.wrEn && regWr.addr == ADDR_RUN_CTRL;
    assign wrL0   = regWr.wrEn && regWr.addr == ADDR_T0_LOW;
    // Shadow of mode byte and run bits
    always_comb begin
        nxt_modeSh = (regWr.wrEn && regWr.addr == ADDR_MODE_CFG) ? regWr.wrData : modeSh_ff;
        nxt_run    = ctrlWr ? {regWr.wrData[CTRL_TR1], regWr.wrData[CTRL_TR0]} : run_ff;
    end
    always_ff @(posedge clk) begin
        modeSh_ff <= rst ? RESET_BYTE : nxt_modeSh;
        run_ff    <= rst ? 2'b00 : nxt_run;
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Two reads of the low byte of timer 0 with no write between
    // Read data trails the address by one edge, so each check lands a cycle later
    sequence l0Quiet;
        rdAddr == ADDR_T0_LOW ##1 (rdAddr == ADDR_T0_LOW && !wrL0);
    endsequence
    AST_RESET_QUIET: assert property (disable iff (1'b0)
        rst |=> rdData == 8'h00 && !t0_overflow_flag && !t1_overflow_flag) else $error("reset left outputs set");
    AST_T0_FLAG_CLEAR: assert property ($fell(t0_overflow_flag) |->
        $past(t0_isr_enter) || $past(t0_isr_enter, 2) || $past(ctrlWr) || $past(ctrlWr, 2)) else $error("t0 flag fell");
    AST_T1_FLAG_CLEAR: assert property ($fell(t1_overflow_flag) |->
        $past(t1_isr_enter) || $past(t1_isr_enter, 2) || $past(ctrlWr) || $past(ctrlWr, 2)) else $error("t1 flag fell");
    AST_UNMAPPED_READ: assert property (
        rdAddr < ADDR_RUN_CTRL || rdAddr > ADDR_T1_HIGH |=> rdData == 8'h00) else $error("unmapped read not zero");
    AST_MODE_READBACK: assert property (
        regWr.wrEn && regWr.addr == ADDR_MODE_CFG && rdAddr == ADDR_MODE_CFG |=> rdData == $past(regWr.wrData))
        else $error("mode byte readback wrong");
    AST_T0_HALTED: assert property (l0Quiet ##0 !run_ff[0] |=> $stable(rdData)) else $error("halted t0 moved");
    AST_T0_GATED: assert property (
        l0Quiet ##0 (run_ff[0] && modeSh_ff[MODE_T0_HW_GATE_ENABLE] && !ext_irq0_pin) |=> $stable(rdData)) else $error("gated t0 moved");
    AST_T0_RUNS: assert property (
        l0Quiet ##0 (run_ff[0] && modeSh_ff[3:0] == 4'h1) |=> rdData == 8'($past(rdData) + 8'h01)) else $error("t0 not counting");
    AST_T1_SPLIT_HOLDS: assert property (
        rdAddr == ADDR_T1_LOW ##1 (rdAddr == ADDR_T1_LOW && modeSh_ff[5:4] == 2'b11 && !(regWr.wrEn && regWr.addr == ADDR_T1_LOW))
        |=> $stable(rdData)) else $error("split t1 moved");
    cover property ($rose(t0_overflow_flag));
    cover property ($rose(t1_overflow_flag));
    cover property (l0Quiet ##0 (run_ff[0] && modeSh_ff[MODE_T0_HW_GATE_ENABLE] && !ext_irq0_pin));
endmodule

// ===== test/pin_model.sv
/* Far-side pins: gate level and count pulses.
   Assumes the bench drives gateLvl and pulseEn at clk edges. */
`timescale 1ns/1ps
module pin_model (
    input  wire logic clk,
    input  wire logic gateLvl,
    input  wire logic pulseEn,
    output logic      gatePin,
    output logic      cntPin
);
    assign gatePin = gateLvl;
    // Toggle count pin while enabled, park low otherwise
    always_ff @(posedge clk) cntPin <= pulseEn & ~cntPin;
endmodule

// ===== test/testbench.sv
/* Self-checking bench for the dual timer block.
   Assumes the timer package, the pin model and the checker. */
`timescale 1ns/1ps
module testbench
    import timer_mode_pkg::*;
;
    typedef struct {
        logic [7:0] mode, l0, h0, l1, run;
        logic       gate;
        logic [7:0] eL0, eH0, eL1;
        logic [1:0] eFlag;
    } case_s;
    case_s cases[9] = '{
        '{8'h01, 8'hFE, 8'hFF, 8'h00, 8'h10, 1'b0, 8'h07, 8'h00, 8'h00, 2'b01},
        '{8'h00, 8'hFE, 8'h00, 8'h00, 8'h10, 1'b0, 8'hE7, 8'h01, 8'h00, 2'b00},
        '{8'h02, 8'hFE, 8'h80, 8'h00, 8'h10, 1'b0, 8'h87, 8'h80, 8'h00, 2'b01},
        '{8'hF3, 8'h00, 8'hFE, 8'h55, 8'h50, 1'b0, 8'h09, 8'h07, 8'h55, 2'b10},
        '{8'hD0, 8'h00, 8'h00, 8'h00, 8'h40, 1'b0, 8'h00, 8'h00, 8'h09, 2'b00},
        '{8'h09, 8'h00, 8'h00, 8'h00, 8'h10, 1'b0, 8'h00, 8'h00, 8'h00, 2'b00},
        '{8'h09, 8'h00, 8'h00, 8'h00, 8'h10, 1'b1, 8'h09, 8'h00, 8'h00, 2'b00},
        '{8'h20, 8'h00, 8'h00, 8'hFE, 8'h40, 1'b0, 8'h00, 8'h00, 8'h07, 2'b10},
        '{8'h00, 8'h00, 8'h00, 8'hFE, 8'h40, 1'b0, 8'h00, 8'h00, 8'hE7, 2'b00}};
    logic       clk = 0, rst = 1, gateLvl = 0, pulseEn = 0, t0Isr = 0, t1Isr = 0;
    logic       irqPin, cntPin, t0Flag, t1Flag;
    logic [7:0] rdAddr = 8'h00, rdData;
    reg_write_s regWr = '0;
    int         mismatches = 0, num_checks = 0, cyc = 0;
    case_s      c;
    dual_timer_mode_control DUT (.clk, .rst, .regWr, .rdAddr, .ext_irq0_pin(irqPin), .t0_count_pin(cntPin),
        .t0_isr_enter(t0Isr), .t1_isr_enter(t1Isr), .rdData, .t0_overflow_flag(t0Flag), .t1_overflow_flag(t1Flag));
    pin_model partner (.clk, .gateLvl, .pulseEn, .gatePin(irqPin), .cntPin);
    ////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        regWr <= '{wrEn: 1'b1, addr: a, wrData: d};
        @(posedge clk);
        regWr.wrEn <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        rdAddr <= a;
        @(posedge clk);
        #1 chk($sformatf("reg %h", a), exp, rdData);
        @(posedge clk);
    endtask
    task automatic tally_and_finish();
        if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Register checks, then one timed run per mode case, then pin counting
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(ADDR_RUN_CTRL, 8'h00);
        rd(ADDR_MODE_CFG, 8'h00);
        wr(ADDR_MODE_CFG, 8'hC6);
        rd(ADDR_MODE_CFG, 8'hC6);
        wr(8'h90, 8'h5A);
        rd(8'h90, 8'h00);
        foreach (cases[i]) begin
            c = cases[i];
            rdAddr <= (c.mode[5:4] == 2'b11) ? ADDR_T1_LOW : ADDR_T0_LOW;
            gateLvl <= c.gate;
            wr(ADDR_MODE_CFG, c.mode);
            wr(ADDR_T0_LOW, c.l0);
            wr(ADDR_T0_HIGH, c.h0);
            wr(ADDR_T1_LOW, c.l1);
            wr(ADDR_T1_HIGH, 8'h00);
            wr(ADDR_RUN_CTRL, c.run);
            repeat (3) @(posedge clk);
            #1 chk("flags", {6'h00, c.eFlag}, {6'h00, t1Flag, t0Flag});
            @(posedge clk);
            t0Isr <= 1'b1;
            t1Isr <= 1'b1;
            @(posedge clk);
            t0Isr <= 1'b0;
            t1Isr <= 1'b0;
            @(posedge clk);
            #1 chk("flags", 8'h00, {6'h00, t1Flag, t0Flag});
            @(posedge clk);
            wr(ADDR_RUN_CTRL, 8'h00);
            rd(ADDR_T0_LOW, c.eL0);
            rd(ADDR_T0_HIGH, c.eH0);
            rd(ADDR_T1_LOW, c.eL1);
        end
        wr(ADDR_MODE_CFG, 8'h05);
        wr(ADDR_T0_LOW, 8'h00);
        wr(ADDR_RUN_CTRL, 8'h10);
        pulseEn <= 1'b1;
        repeat (6) @(posedge clk);
        pulseEn <= 1'b0;
        repeat (4) @(posedge clk);
        wr(ADDR_RUN_CTRL, 8'h00);
        rd(ADDR_T0_LOW, 8'h03);
        tally_and_finish();
    end
endmodule
bind dual_timer_mode_control dual_timer_checker chk (.clk, .rst, .regWr, .rdAddr, .ext_irq0_pin,
    .t0_isr_enter, .t1_isr_enter, .rdData, .t0_overflow_flag, .t1_overflow_flag);

// ===== verilog/dual_timer_mode_control.sv
/*
 * Dual timer/counter with mode register, run control and overflow flags.
 * Timer 0 counts the core clock or rising edges of its count pin, under an
 * optional hardware gate; timer 1 always counts the core clock.
 * Split mode hands timer 0's high byte to timer 1's run bit and flag, and
 * timer 1 keeps counting in its own mode meanwhile unless it too is set to 11.
 * Assumes pins synchronous to clk and the core's special-register port
 * (write strobe, address, data; combinational read data is registered here).
 * Assumes the core raises a one-cycle service-entry pulse per timer.
 * The count pin must stay high and low for at least one clock per pulse.
 */
`timescale 1ns/1ps
module dual_timer_mode_control
    import timer_mode_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire reg_write_s  regWr,
    input  wire logic [7:0]  rdAddr,
    input  wire logic        ext_irq0_pin,
    input  wire logic        t0_count_pin,
    input  wire logic        t0_isr_enter,
    input  wire logic        t1_isr_enter,
    output logic      [7:0]  rdData,
    output logic             t0_overflow_flag,
    output logic             t1_overflow_flag
);

    ////////////////////////////////////////////////////////////////////////
    // Register state
    logic [7:0]  timer_mode_config_ff, nxt_timer_mode_config;
    logic [7:0]  timer_run_control_ff, nxt_timer_run_control;
    count_pair_s t0_ff, nxt_t0;
    count_pair_s t1_ff, nxt_t1;
    logic        countPinPrev_ff, nxt_countPinPrev;
    logic [7:0]  rdData_ff, nxt_rdData;

    // Mode decode, count qualifiers and byte increments
    timer_mode_e t0Mode, t1Mode;
    logic        t0_run, t1_run, t0Tick, t1Tick;
    logic        t0Ovf, t0HighOvf, t1Ovf;
    logic [7:0]  t0LowInc, t0HighInc, t1LowInc, t1HighInc;

    // Gate, source and mode decode
    always_comb begin
        t0Mode = timer_mode_e'({timer_mode_config_ff[MODE_T0_HI],
                                timer_mode_config_ff[MODE_T0_LO]});   // see R4
        t1Mode = timer_mode_e'({timer_mode_config_ff[MODE_T1_HI],
                                timer_mode_config_ff[MODE_T1_LO]});   // see R4
        t0_run = timer_run_control_ff[CTRL_TR0];                      // see R10
        t1_run = timer_run_control_ff[CTRL_TR1];                      // see R10, R9
        // Gate high needs pin high; gate low ignores pin
        t0Tick = t0_run && (!timer_mode_config_ff[MODE_T0_HW_GATE_ENABLE] || ext_irq0_pin)           // see R1, R2
                 && (timer_mode_config_ff[MODE_SRC0] ? (t0_count_pin && !countPinPrev_ff)
                                                      : 1'b1);        // see R3
        t1Tick = t1_run;                                              // see R9
        // Plain byte increments; the wrap past all ones is the overflow case
        t0LowInc  = t0_ff.low + 8'h01;
        t0HighInc = t0_ff.high + 8'h01;
        t1LowInc  = t1_ff.low + 8'h01;
        t1HighInc = t1_ff.high + 8'h01;
    end

    ////////////////////////////////////////////////////////////////////////
    // Counting, overflow flags and register writes
    always_comb begin
        nxt_t0                = t0_ff;
        nxt_t1                = t1_ff;
        nxt_timer_mode_config = timer_mode_config_ff;
        nxt_timer_run_control = timer_run_control_ff;
        nxt_countPinPrev      = t0_count_pin;
        t0Ovf                 = 1'b0;
        t0HighOvf             = 1'b0;
        t1Ovf                 = 1'b0;

        // Timer 0 on its own run, gate and source
        if (t0Tick) begin
            case (t0Mode)
                // Five low bits carry into the high byte; low[7:5] kept
                MODE_13BIT: begin                                     // see R13, R5
                    if ((t0_ff.low & LOW13_MASK) == {3'b000, LOW13_MAX}) begin
                        nxt_t0.low  = t0_ff.low & ~LOW13_MASK;
                        nxt_t0.high = t0HighInc;
                        t0Ovf       = (t0_ff.high == BYTE_MAX);
                    end else begin
                        nxt_t0.low  = t0LowInc;
                    end
                end
                // Low byte carries into the high byte
                MODE_16BIT: begin                                     // see R5
                    nxt_t0.low = t0LowInc;
                    if (t0_ff.low == BYTE_MAX) begin
                        nxt_t0.high = t0HighInc;
                        t0Ovf       = (t0_ff.high == BYTE_MAX);
                    end
                end
                // Low byte wraps to the reload value held in the high byte
                MODE_RELOAD: begin                                    // see R12, R5
                    nxt_t0.low = (t0_ff.low == BYTE_MAX) ? t0_ff.high : t0LowInc;
                    t0Ovf      = (t0_ff.low == BYTE_MAX);
                end
                // Split: only the low byte answers to timer 0
                default: begin                                        // see R6
                    nxt_t0.low = t0LowInc;
                    t0Ovf      = (t0_ff.low == BYTE_MAX);
                end
            endcase
        end

        // Split mode: high byte runs on timer 1 controls
        if (t0Mode == MODE_SPLIT && t1_run) begin                     // see R7
            nxt_t0.high = t0HighInc;
            t0HighOvf   = (t0_ff.high == BYTE_MAX);
        end

        // Timer 1 holds in mode 11
        if (t1Tick && t1Mode != MODE_SPLIT) begin                     // see R8
            case (t1Mode)
                // Five low bits carry into the high byte; low[7:5] kept
                MODE_13BIT: begin                                     // see R13
                    if ((t1_ff.low & LOW13_MASK) == {3'b000, LOW13_MAX}) begin
                        nxt_t1.low  = t1_ff.low & ~LOW13_MASK;
                        nxt_t1.high = t1HighInc;
                        t1Ovf       = (t1_ff.high == BYTE_MAX);
                    end else begin
                        nxt_t1.low  = t1LowInc;
                    end
                end
                // Low byte carries into the high byte
                MODE_16BIT: begin                                     // see R5
                    nxt_t1.low = t1LowInc;
                    if (t1_ff.low == BYTE_MAX) begin
                        nxt_t1.high = t1HighInc;
                        t1Ovf       = (t1_ff.high == BYTE_MAX);
                    end
                end
                // Low byte wraps to the reload value held in the high byte
                default: begin                                        // see R12
                    nxt_t1.low = (t1_ff.low == BYTE_MAX) ? t1_ff.high : t1LowInc;
                    t1Ovf      = (t1_ff.low == BYTE_MAX);
                end
            endcase
        end

        // Software writes first, hardware events after so sets win
        if (regWr.wrEn) begin
            if (regWr.addr == ADDR_MODE_CFG) begin
                nxt_timer_mode_config = regWr.wrData;
            end else if (regWr.addr == ADDR_RUN_CTRL) begin
                nxt_timer_run_control = regWr.wrData;
            end else if (regWr.addr == ADDR_T0_LOW) begin
                nxt_t0.low = regWr.wrData;
            end else if (regWr.addr == ADDR_T1_LOW) begin
                nxt_t1.low = regWr.wrData;
            end else if (regWr.addr == ADDR_T0_HIGH) begin
                nxt_t0.high = regWr.wrData;
            end else if (regWr.addr == ADDR_T1_HIGH) begin
                nxt_t1.high = regWr.wrData;
            end
        end

        // Service entry clears, overflow sets
        if (t0_isr_enter) begin
            nxt_timer_run_control[CTRL_TF0] = 1'b0;                   // see R11
        end
        if (t1_isr_enter) begin
            nxt_timer_run_control[CTRL_TF1] = 1'b0;                   // see R11
        end
        if (t0Ovf) begin
            nxt_timer_run_control[CTRL_TF0] = 1'b1;                   // see R11
        end
        if (t1Ovf || t0HighOvf) begin
            nxt_timer_run_control[CTRL_TF1] = 1'b1;                   // see R11, R7
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux
    always_comb begin
        if (rdAddr == ADDR_MODE_CFG) begin
            nxt_rdData = nxt_timer_mode_config;
        end else if (rdAddr == ADDR_RUN_CTRL) begin
            nxt_rdData = nxt_timer_run_control;
        end else if (rdAddr == ADDR_T0_LOW) begin
            nxt_rdData = nxt_t0.low;
        end else if (rdAddr == ADDR_T1_LOW) begin
            nxt_rdData = nxt_t1.low;
        end else if (rdAddr == ADDR_T0_HIGH) begin
            nxt_rdData = nxt_t0.high;
        end else if (rdAddr == ADDR_T1_HIGH) begin
            nxt_rdData = nxt_t1.high;
        end else begin
            nxt_rdData = RESET_BYTE;
        end
    end

    // State registers
    always_ff @(posedge clk) begin
        if (rst) begin
            timer_mode_config_ff <= RESET_BYTE;
            timer_run_control_ff <= RESET_BYTE;
            t0_ff                <= '0;
            t1_ff                <= '0;
            countPinPrev_ff      <= 1'b0;
            rdData_ff            <= RESET_BYTE;
            t0_overflow_flag     <= 1'b0;
            t1_overflow_flag     <= 1'b0;
        end else begin
            timer_mode_config_ff <= nxt_timer_mode_config;
            timer_run_control_ff <= nxt_timer_run_control;
            t0_ff                <= nxt_t0;
            t1_ff                <= nxt_t1;
            countPinPrev_ff      <= nxt_countPinPrev;
            rdData_ff            <= nxt_rdData;
            t0_overflow_flag     <= nxt_timer_run_control[CTRL_TF0];
            t1_overflow_flag     <= nxt_timer_run_control[CTRL_TF1];
        end
    end

    // Read data straight from its register
    assign rdData = rdData_ff;

endmodule

// ===== verilog/timer_mode_pkg.sv
/*
 * Constants, field positions and carrier types for the dual timer mode block.
 * Assumes a single core clock and an 8-bit special-register port from the core.
 */
// Contract
// R1: Timer 0 with run set and gate 1 counts only while interrupt-0 pin is high.
// R2: Timer 0 with gate 0 counts whenever its run bit is 1.
// R3: Timer 0 source bit: 0 counts system clock, 1 counts the timer 0 pin.
// R4: Each timer has a two-bit mode field: timer 1 bits 5:4, timer 0 bits 1:0.
// R5: Mode 00 is 13-bit, 01 is 16-bit, 10 is 8-bit auto-reload.
// R6: Mode 11: timer 0 low byte counts alone under timer 0 run, gate, source.
// R7: Mode 11: timer 0 high byte counts under timer 1 run and overflow flag.
// R8: Mode 11 on timer 1: its bytes hold and it does not count.
// R9: Timer 1 gate and source bits 7:6 do nothing; timer 1 counts internal clock.
// R10: Run bit 1 starts a timer, 0 halts it.
// R11: Overflow sets the flag; entering the service routine clears it.
// R12: Auto-reload: low byte counts, reloads from high byte on overflow.
// R13: 13-bit mode: high byte above five low bits of the low byte.
package timer_mode_pkg;
    localparam logic [7:0] ADDR_RUN_CTRL  = 8'h88;
    localparam logic [7:0] ADDR_MODE_CFG  = 8'h89;
    localparam logic [7:0] ADDR_T0_LOW    = 8'h8A;
    localparam logic [7:0] ADDR_T1_LOW    = 8'h8B;
    localparam logic [7:0] ADDR_T0_HIGH   = 8'h8C;
    localparam logic [7:0] ADDR_T1_HIGH   = 8'h8D;
    localparam logic [7:0] RESET_BYTE     = 8'h00;
    localparam logic [7:0] LOW13_MASK     = 8'h1F;
    localparam logic [7:0] BYTE_MAX       = 8'hFF;
    localparam logic [4:0] LOW13_MAX      = 5'h1F;
    // Mode register field positions
    localparam int MODE_T0_HW_GATE_ENABLE = 3;
    localparam int MODE_SRC0  = 2;
    localparam int MODE_T1_HI = 5;
    localparam int MODE_T1_LO = 4;
    localparam int MODE_T0_HI = 1;
    localparam int MODE_T0_LO = 0;
    // Run control field positions
    localparam int CTRL_TF1 = 7;
    localparam int CTRL_TR1 = 6;
    localparam int CTRL_TF0 = 5;
    localparam int CTRL_TR0 = 4;

    typedef enum logic [1:0] {
        MODE_13BIT  = 2'b00,
        MODE_16BIT  = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT  = 2'b11
    } timer_mode_e;

    typedef struct packed {
        logic [7:0] low;
        logic [7:0] high;
    } count_pair_s;

    typedef struct packed {
        logic       wrEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } reg_write_s;
endpackage
